// ==== dsp_access_regs.svh ====
// Purpose: constants of the core command decoder
// Assumes: 250 MHz system clock
// Notes: offsets and codes shared by the design files
`ifndef DSP_ACCESS_REGS_SVH
`define DSP_ACCESS_REGS_SVH

// ************************************************
// subaddresses of the control link
// ************************************************
`define SUB_CORE_WR 8'h68
`define SUB_CORE_RD 8'h69
`define SUB_DCDC 8'h76

// ************************************************
// command codes
// ************************************************
`define CMD_RUN_MAX 4'h3
`define CMD_ANC 4'h5
`define CMD_DOWNLOAD 4'h6
`define CMD_REG_RD 4'hA
`define CMD_REG_WR 4'hB
`define CMD_RD_BANK0 4'hC
`define CMD_RD_BANK1 4'hD
`define CMD_WR_BANK0 4'hE
`define CMD_WR_BANK1 4'hF
`define AUX_SHORT 4'h4

// ************************************************
// run address window and reset values
// ************************************************
`define RUN_PROG_LO 16'h1000
`define RUN_PROG_HI 16'h3FFF
`define DCDC_RESET 8'h00
`define DCDC_SEL_MSB 3

// ************************************************
// timing
// ************************************************
`define CLK_MHZ 250
`define RESP_MAX_US 4000
`define RESP_TYP_US 500
`define RESP_MAX_CYC (`RESP_MAX_US * `CLK_MHZ)

`endif

// ==== dsp_access_pkg.sv ====
// Purpose: types of the core command decoder
// Assumes: nothing
// Notes: state struct of the decoder lives here
package dsp_access_pkg;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_SUB, ST_WR, ST_RD, ST_IGNORE
   } link_st_t;

   typedef enum logic [1:0] {
      RM_NONE, RM_REG, RM_MEM, RM_ANC
   } rd_mode_t;

   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic scl_q;
      logic sda_q;
      link_st_t st;
      logic [3:0] bitcnt;
      logic ack_slot;
      logic ack_me;
      logic nack;
      logic rd_sent;
      logic load;
      logic [7:0] shreg;
      logic [7:0] sub;
      logic [1:0] wi;
      logic byte_hi;
      logic [7:0] wbuf;
      logic [3:0] cmd;
      logic short_acc;
      logic [15:0] w0;
      logic [15:0] w1;
      logic [15:0] cnt;
      logic [10:0] ptr;
      logic [3:0] pend;
      logic half;
      rd_mode_t rmode;
      logic [19:0] rd_hold;
      logic rd_bank;
      logic rd_short;
      logic rd_half;
      logic [10:0] rd_ptr;
      logic tx_lo;
      logic sda_oe_n;
      logic [7:0] dcdc;
      logic frozen;
      logic custom;
      logic run_pulse;
      logic [15:0] run_addr;
      logic reg_we;
      logic [7:0] reg_addr;
      logic [19:0] reg_wdata;
      logic anc_take;
      logic dl_act;
      logic [10:0] dl_ptr;
      logic [11:0] dl_left;
      logic dl_hi;
      logic [3:0] dl_d4;
      logic mem_we;
      logic mem_bank;
      logic [10:0] mem_addr;
      logic [19:0] mem_wdata;
   } dec_state_t;

endpackage : dsp_access_pkg

// ==== dsp_ram_banks.sv ====
// Purpose: two data RAM banks of 2048 words of 20 bits
// Assumes: one write and one read port, same clock
// Notes: read data come out of a register
`timescale 1ns/100ps
module dsp_ram_banks (
   // clock
   input wire logic clock,
   input wire logic clk_en,
   // write port
   input wire logic we,
   input wire logic wbank,
   input wire logic [10:0] waddr,
   input wire logic [19:0] wdata,
   // read port
   input wire logic rbank,
   input wire logic [10:0] raddr,
   output logic [19:0] rdata
);
   logic [19:0] rd_word [2];

   // ************************************************
   // banks, independent ports so the core keeps running
   // ************************************************
   for (genvar b = 0; b < 2; b++) begin : g_bank
      logic [19:0] mem [2048];
      always_ff @(posedge clock) begin
         if (clk_en && we && (wbank == 1'(b))) begin
            mem[waddr] <= wdata;
         end
      end
      assign rd_word[b] = mem[raddr];
   end

   always_ff @(posedge clock) begin
      if (clk_en) begin
         rdata <= rbank ? rd_word[1] : rd_word[0];
      end
   end

endmodule : dsp_ram_banks

// ==== dsp_core_access.sv ====
// Purpose: control-link command decoder for the audio core
// Assumes: link pins sampled by the system clock
// Notes: memory block writes stream as words arrive
//
// Operation
// - two data RAM banks, 20-bit words each
// - every RAM word reachable as full 20 bits or short 16 bits
// - separate space of 256 core registers
// - host commands served without stalling core data streams
// - response within 4 ms, typically below 0.5 ms; host waits
// - command code is first nibble after core-write subaddress
// - second nibble selects short 16-bit memory access
// - telegrams carry whole 16-bit words
// - codes 0 to 3 mean run at the given address
// - code 5 returns ancillary data to the host
// - code 6 starts download through the parallel port
// - read-register returns one addressed register
// - code B writes one addressed register
// - codes C and D read blocks from bank zero and one
// - codes E and F write blocks into bank zero and one
// - run in 1000 to 3FFF with program RAM continues custom code; the code takes 1000 to 3FFE only
// - run at address zero freezes execution
// - converter bits 3 to 0 pick frequency, default 0000
// - write-register carries 8-bit number and 20-bit value
// - short write keeps low 16 bits, clears upper four
`timescale 1ns/100ps
`include "dsp_access_regs.svh"
module dsp_core_access #(
   parameter logic [6:0] DEV_ADDR = 7'h1E // arbitrary value
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   // control link
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // program control
   input wire logic prog_ram_en,
   output logic run_pulse,
   output logic [15:0] run_addr,
   output logic frozen,
   output logic run_custom,
   // core registers
   output logic reg_we,
   output logic [7:0] reg_addr,
   output logic [19:0] reg_wdata,
   input wire logic [19:0] reg_rdata,
   // ancillary data
   input wire logic [15:0] anc_data,
   output logic anc_take,
   // parallel port download
   input wire logic pio_valid,
   input wire logic [15:0] pio_data,
   output logic dl_busy,
   // converter control
   output logic [3:0] dcdc_freq_sel
);
   dsp_access_pkg::dec_state_t r;
   dsp_access_pkg::dec_state_t n;
   logic [19:0] mem_rdata;
   logic scl_new;
   logic sda_new;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [7:0] b_in;
   logic [15:0] w_in;
   logic [15:0] tx_word;
   logic [7:0] tx_byte;
   logic in_window;

   // ************************************************
   // pin filtering and edges
   // ************************************************
   always_comb begin
      scl_new = (r.scl_s[1] == r.scl_s[2]) ? r.scl_s[2] : r.scl_q;
      sda_new = (r.sda_s[1] == r.sda_s[2]) ? r.sda_s[2] : r.sda_q;
      scl_rise = scl_new && !r.scl_q;
      scl_fall = !scl_new && r.scl_q;
      start_c = r.scl_q && scl_new && r.sda_q && !sda_new;
      stop_c = r.scl_q && scl_new && !r.sda_q && sda_new;
      b_in = {r.shreg[6:0], sda_new};
      w_in = {r.wbuf, b_in};
      in_window = (r.w0 >= `RUN_PROG_LO) && (r.w0 < `RUN_PROG_HI);
   end

   // ************************************************
   // byte to send on a read
   // ************************************************
   always_comb begin
      logic [19:0] src;
      src = (r.rmode == dsp_access_pkg::RM_MEM) ? mem_rdata : r.rd_hold;
      if (r.rmode == dsp_access_pkg::RM_ANC) begin
         tx_word = anc_data;
      end else if (r.rd_short) begin
         tx_word = src[15:0];
      end else if (!r.rd_half) begin
         tx_word = {12'h000, src[19:16]};
      end else begin
         tx_word = src[15:0];
      end
      tx_byte = r.tx_lo ? tx_word[7:0] : tx_word[15:8];
   end

   // ************************************************
   // decoder
   // ************************************************
   always_comb begin
      n = r;
      n.scl_s = {r.scl_s[1:0], scl};
      n.sda_s = {r.sda_s[1:0], sda_in};
      n.scl_q = scl_new;
      n.sda_q = sda_new;
      n.run_pulse = 1'b0;
      n.reg_we = 1'b0;
      n.anc_take = 1'b0;
      n.mem_we = 1'b0;
      n.load = 1'b0;

      if (r.load) begin
         n.sda_oe_n = tx_byte[7];
      end

      // telegram ends: execute the command
      if ((start_c || stop_c) && r.st == dsp_access_pkg::ST_WR
          && r.sub == `SUB_CORE_WR && r.wi != 2'd0
          && !r.byte_hi) begin
         if (r.cmd <= `CMD_RUN_MAX) begin
            if (r.w0 == 16'h0000) begin
               n.frozen = 1'b1;
               n.custom = 1'b0;
            end else begin
               n.frozen = 1'b0;
               n.run_pulse = 1'b1;
               n.run_addr = r.w0;
               n.custom = in_window && prog_ram_en;
            end
         end else if (r.cmd == `CMD_ANC) begin
            n.rmode = dsp_access_pkg::RM_ANC;
            n.rd_short = 1'b1;
         end else if (r.cmd == `CMD_DOWNLOAD && r.wi >= 2'd2) begin
            n.dl_act = (r.w0[11:0] != 12'h000);
            n.dl_left = r.w0[11:0];
            n.dl_ptr = r.w1[10:0];
            n.dl_hi = 1'b1;
         end else if (r.cmd == `CMD_REG_RD) begin
            n.rmode = dsp_access_pkg::RM_REG;
            n.reg_addr = r.w0[11:4];
            n.rd_short = 1'b0;
         end else if (r.cmd == `CMD_REG_WR && r.wi >= 2'd2) begin
            n.reg_we = 1'b1;
            n.reg_addr = r.w0[11:4];
            n.reg_wdata = {r.w0[3:0], r.w1};
         end else if ((r.cmd == `CMD_RD_BANK0 || r.cmd == `CMD_RD_BANK1)
                      && r.wi == 2'd3) begin
            n.rmode = dsp_access_pkg::RM_MEM;
            n.rd_bank = (r.cmd == `CMD_RD_BANK1);
            n.rd_short = r.short_acc;
         end
         // any other code falls through untouched
      end

      if (start_c) begin
         n.st = dsp_access_pkg::ST_ADDR;
         n.bitcnt = 4'd0;
         n.ack_slot = 1'b0;
         n.wi = 2'd0;
         n.byte_hi = 1'b0;
         n.half = 1'b0;
         n.sda_oe_n = 1'b1;
      end else if (stop_c) begin
         n.st = dsp_access_pkg::ST_IDLE;
         n.sda_oe_n = 1'b1;
      end else if (scl_rise && r.st != dsp_access_pkg::ST_IDLE) begin
         if (r.ack_slot) begin
            if (r.st == dsp_access_pkg::ST_RD) begin
               n.nack = sda_new;
            end
         end else if (r.bitcnt < 4'd8) begin
            n.shreg = b_in;
            n.bitcnt = r.bitcnt + 4'd1;
            n.ack_me = 1'b0;
            n.rd_sent = 1'b0;
            if (r.bitcnt == 4'd7) begin
               case (r.st)
                  dsp_access_pkg::ST_ADDR: begin
                     if (b_in[7:1] == DEV_ADDR) begin
                        n.ack_me = 1'b1;
                        if (b_in[0]) begin
                           n.st = dsp_access_pkg::ST_RD;
                           n.nack = 1'b0;
                           n.tx_lo = 1'b0;
                           n.rd_half = 1'b0;
                           n.rd_hold = reg_rdata;
                        end else begin
                           n.st = dsp_access_pkg::ST_SUB;
                        end
                     end else begin
                        n.st = dsp_access_pkg::ST_IGNORE;
                     end
                  end
                  dsp_access_pkg::ST_SUB: begin
                     n.ack_me = 1'b1;
                     n.sub = b_in;
                     n.st = dsp_access_pkg::ST_WR;
                  end
                  dsp_access_pkg::ST_WR: begin
                     n.ack_me = 1'b1;
                     n.byte_hi = !r.byte_hi;
                     if (!r.byte_hi) begin
                        n.wbuf = b_in;
                     end else if (r.sub == `SUB_DCDC) begin
                        n.dcdc = w_in[7:0];
                     end else if (r.sub == `SUB_CORE_WR) begin
                        if (r.wi != 2'd3) begin
                           n.wi = r.wi + 2'd1;
                        end
                        if (r.wi == 2'd0) begin
                           n.cmd = w_in[15:12];
                           n.short_acc = (w_in[11:8] == `AUX_SHORT);
                           n.w0 = w_in;
                        end else if (r.wi == 2'd1) begin
                           n.w1 = w_in;
                        end else if (r.wi == 2'd2) begin
                           n.ptr = w_in[10:0];
                           n.rd_ptr = w_in[10:0];
                           n.cnt = r.w1;
                        end else if ((r.cmd == `CMD_WR_BANK0
                                      || r.cmd == `CMD_WR_BANK1)
                                     && r.cnt != 16'h0000) begin
                           if (r.short_acc || r.half) begin
                              n.mem_we = 1'b1;
                              n.mem_bank = (r.cmd == `CMD_WR_BANK1);
                              n.mem_addr = r.ptr;
                              n.mem_wdata = r.short_acc
                                 ? {4'h0, w_in} : {r.pend, w_in};
                              n.ptr = r.ptr + 11'd1;
                              n.cnt = r.cnt - 16'd1;
                              n.half = 1'b0;
                           end else begin
                              n.pend = w_in[3:0];
                              n.half = 1'b1;
                           end
                        end
                     end
                  end
                  dsp_access_pkg::ST_RD: begin
                     n.rd_sent = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
      end else if (scl_fall && r.st != dsp_access_pkg::ST_IDLE) begin
         if (r.bitcnt == 4'd8 && !r.ack_slot) begin
            n.ack_slot = 1'b1;
            n.sda_oe_n = !r.ack_me;
         end else if (r.ack_slot) begin
            n.ack_slot = 1'b0;
            n.bitcnt = 4'd0;
            n.sda_oe_n = 1'b1;
            if (r.st == dsp_access_pkg::ST_RD && !r.nack) begin
               n.load = 1'b1;
               if (r.rd_sent) begin
                  n.tx_lo = !r.tx_lo;
                  if (r.tx_lo) begin
                     if (r.rmode == dsp_access_pkg::RM_ANC) begin
                        n.anc_take = 1'b1;
                     end else if (!r.rd_short && !r.rd_half) begin
                        n.rd_half = 1'b1;
                     end else begin
                        n.rd_half = 1'b0;
                        n.rd_ptr = r.rd_ptr + 11'd1;
                     end
                  end
               end
            end
         end else if (r.st == dsp_access_pkg::ST_RD && !r.nack
                      && r.bitcnt < 4'd8) begin
            n.sda_oe_n = tx_byte[3'd7 - r.bitcnt[2:0]];
         end
      end

      // parallel port download, bank zero
      if (r.dl_act && pio_valid) begin
         if (r.dl_hi) begin
            n.dl_d4 = pio_data[3:0];
            n.dl_hi = 1'b0;
         end else begin
            n.mem_we = 1'b1;
            n.mem_bank = 1'b0;
            n.mem_addr = r.dl_ptr;
            n.mem_wdata = {r.dl_d4, pio_data};
            n.dl_ptr = r.dl_ptr + 11'd1;
            n.dl_left = r.dl_left - 12'd1;
            n.dl_hi = 1'b1;
            n.dl_act = (r.dl_left != 12'd1);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         r <= '0;
         r.scl_s <= 3'h7;
         r.sda_s <= 3'h7;
         r.scl_q <= 1'b1;
         r.sda_q <= 1'b1;
         r.st <= dsp_access_pkg::ST_IDLE;
         r.rmode <= dsp_access_pkg::RM_NONE;
         r.sda_oe_n <= 1'b1;
         r.dcdc <= `DCDC_RESET;
      end else if (clk_en) begin
         r <= n;
      end
   end

   // ************************************************
   // RAM banks
   // ************************************************
   dsp_ram_banks u_ram (
      .clock(clock),
      .clk_en(clk_en),
      .we(r.mem_we),
      .wbank(r.mem_bank),
      .waddr(r.mem_addr),
      .wdata(r.mem_wdata),
      .rbank(n.rd_bank),
      .raddr(n.rd_ptr),
      .rdata(mem_rdata)
   );

   // ************************************************
   // outputs
   // ************************************************
   assign sda_out = 1'b0;
   assign sda_oe_n = r.sda_oe_n;
   assign run_pulse = r.run_pulse;
   assign run_addr = r.run_addr;
   assign frozen = r.frozen;
   assign run_custom = r.custom;
   assign reg_we = r.reg_we;
   assign reg_addr = r.reg_addr;
   assign reg_wdata = r.reg_wdata;
   assign anc_take = r.anc_take;
   assign dl_busy = r.dl_act;
   assign dcdc_freq_sel = r.dcdc[`DCDC_SEL_MSB:0];

endmodule : dsp_core_access

// ==== dsp_access_monitor.sv ====
// Purpose: port checker of the core command decoder
// Assumes: clk_en low only while the link is idle
// Notes: bound to dsp_core_access below
`timescale 1ns/100ps
module dsp_access_monitor (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // observed outputs
   input wire logic sda_oe_n,
   input wire logic run_pulse,
   input wire logic [15:0] run_addr,
   input wire logic frozen,
   input wire logic run_custom,
   input wire logic reg_we,
   input wire logic anc_take,
   input wire logic dl_busy,
   input wire logic [3:0] dcdc_freq_sel
);
   // ********
   // checks
   // ********
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_rst;
      $rose(rst_n) |-> sda_oe_n && !frozen && !run_custom && !dl_busy
         && dcdc_freq_sel == 4'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_we;
      reg_we |=> !reg_we;
   endproperty
   a_we: assert property (p_we) else $error("long write");
   property p_run;
      run_pulse |-> !frozen && run_addr != 16'h0000 ##1 !run_pulse;
   endproperty
   a_run: assert property (p_run) else $error("bad run pulse");
   property p_frz;
      $rose(frozen) |-> !run_pulse;
   endproperty
   a_frz: assert property (p_frz) else $error("run on freeze");
   property p_cust;
      $rose(run_custom) |-> run_addr >= 16'h1000 && run_addr < 16'h3FFF;
   endproperty
   a_cust: assert property (p_cust) else $error("custom out of range");
   property p_anc;
      anc_take |=> !anc_take;
   endproperty
   a_anc: assert property (p_anc) else $error("long anc take");
   property p_excl;
      reg_we |-> !run_pulse && !anc_take;
   endproperty
   a_excl: assert property (p_excl) else $error("two actions");
   property p_bit;
      $fell(sda_oe_n) |=> !sda_oe_n [*8];
   endproperty
   a_bit: assert property (p_bit) else $error("short drive");
   property p_done;
      (reg_we || run_pulse) |-> sda_oe_n;
   endproperty
   a_done: assert property (p_done) else $error("act in frame");
endmodule : dsp_access_monitor

bind dsp_core_access dsp_access_monitor mon (.clock, .rst_n, .sda_oe_n,
   .run_pulse, .run_addr, .frozen, .run_custom, .reg_we, .anc_take,
   .dl_busy, .dcdc_freq_sel);

// ==== i2c_host_model.sv ====
// Purpose: host controller on the control link
// Assumes: pull-up on the data line
// Notes: 48 ns bit time, link clock idle high
`timescale 1ns/100ps
module i2c_host_model (
   // link
   output logic scl,
   output logic sda_drv,
   input wire logic sda_line
);
   // ********
   // bit and byte tasks
   // ********
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic put_bit(input logic b);
      sda_drv = b;
      #12 scl = 1'b1;
      #24 scl = 1'b0;
      #12;
   endtask : put_bit
   // late rise leaves room for the device to turn data round
   task automatic get_bit(output logic v);
      sda_drv = 1'b1;
      #26 scl = 1'b1;
      #16 v = sda_line;
      scl = 1'b0;
      #6;
   endtask : get_bit
   task automatic start();
      sda_drv = 1'b1;
      #12 scl = 1'b1;
      #24 sda_drv = 1'b0;
      #24 scl = 1'b0;
      #12;
   endtask : start
   task automatic stop();
      sda_drv = 1'b0;
      #12 scl = 1'b1;
      #24 sda_drv = 1'b1;
      #24;
   endtask : stop
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic v;
      for (int i = 7; i >= 0; i--) put_bit(b[i]);
      get_bit(v);
      ack = !v;
   endtask : put_byte
   task automatic get_byte(input logic nak, output logic [7:0] b);
      for (int i = 7; i >= 0; i--) get_bit(b[i]);
      put_bit(nak);
   endtask : get_byte
endmodule : i2c_host_model

// ==== tb_dsp_core_access.sv ====
// Purpose: self-checking bench of the core command decoder
// Assumes: device address 7'h1E
// Notes: telegrams driven through the host model
`timescale 1ns/100ps
module tb_dsp_core_access;
   logic clock, rst_n, sda_out, sda_oe_n, prog_ram_en, run_pulse;
   logic frozen, run_custom, reg_we, anc_take, pio_valid, dl_busy;
   logic scl, sda_drv, clk_en;
   logic [15:0] run_addr, anc_data, pio_data;
   logic [19:0] reg_wdata, reg_rdata, we_data;
   logic [7:0] reg_addr, we_addr;
   logic [3:0] dcdc_freq_sel;
   int errors, samples_checked, cycles, n_we, n_run, n_anc, k;
   typedef logic [7:0] bq_t[$];
   typedef logic [15:0] wq_t[$];
   logic [15:0] ra[6] = '{16'h0345, 16'h3000, 16'h3FFF, 16'h1000,
      16'h1000, 16'h0000};
   logic pe[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   logic [3:0] unused_code[4] = '{4'h4, 4'h7, 4'h8, 4'h9};
   wire sda_line = sda_drv & (sda_oe_n | sda_out);
   assign reg_rdata = {reg_addr[3:0], 8'h5A, reg_addr};
   dsp_core_access DUT (.clock, .rst_n, .clk_en, .scl,
      .sda_in(sda_line), .sda_out, .sda_oe_n, .prog_ram_en, .run_pulse,
      .run_addr, .frozen, .run_custom, .reg_we, .reg_addr, .reg_wdata,
      .reg_rdata, .anc_data, .anc_take, .pio_valid, .pio_data, .dl_busy,
      .dcdc_freq_sel);
   i2c_host_model host (.scl, .sda_drv, .sda_line);
   // ********
   // clock, pulse counts, timeout
   // ********
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      n_run += int'(run_pulse);
      n_anc += int'(anc_take);
      if (reg_we) begin
         n_we++;
         we_addr = reg_addr;
         we_data = reg_wdata;
      end
      if (cycles == 80000) begin
         errors++;
         report_and_stop();
      end
   end
   // ********
   // tasks
   // ********
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic settle();
      repeat (20) @(posedge clock);
      #1;
   endtask : settle
   task automatic wr(input logic [7:0] sub, input bq_t q);
      logic ack;
      host.start();
      host.put_byte(8'h3C, ack);
      host.put_byte(sub, ack);
      foreach (q[i]) begin
         host.put_byte(q[i], ack);
         check(20'(ack), 20'h1);
      end
      host.stop();
      settle();
   endtask : wr
   task automatic rd(input wq_t e);
      logic ack;
      logic [7:0] hi, lo;
      host.start();
      host.put_byte(8'h3D, ack);
      foreach (e[i]) begin
         host.get_byte(1'b0, hi);
         host.get_byte(i == e.size() - 1, lo);
         check({4'h0, hi, lo}, {4'h0, e[i]});
      end
      host.stop();
      settle();
   endtask : rd
   task automatic parallel_io_port(input logic [15:0] w);
      @(posedge clock);
      #1 pio_valid = 1'b1;
      pio_data = w;
      @(posedge clock);
      #1 pio_valid = 1'b0;
   endtask : parallel_io_port
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   // ********
   // tests
   // ********
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      prog_ram_en = 1'b0;
      anc_data = 16'h1357;
      pio_valid = 1'b0;
      pio_data = 16'h0000;
      repeat (2) @(posedge clock);
      #1 rst_n = 1'b1;
      settle();
      check(20'(dcdc_freq_sel), 20'h0);
      check(20'(frozen), 20'h0);
      check(20'(sda_out), 20'h0);
      wr(8'h68, '{8'hBA, 8'hA8, 8'h12, 8'h34});
      check(20'(we_addr), 20'hAA);
      check(we_data, 20'h81234);
      wr(8'h68, '{8'hBA, 8'hA8, 8'h12});
      foreach (unused_code[i])
         wr(8'h68, '{{unused_code[i], 4'h0}, 8'h00});
      check(20'(n_we), 20'h1);
      check(20'(n_run), 20'h0);
      check(20'(frozen), 20'h0);
      $display("test register write done");
      foreach (ra[i]) begin
         prog_ram_en = pe[i];
         k = n_run;
         wr(8'h68, '{ra[i][15:8], ra[i][7:0]});
         check(20'(frozen), 20'(ra[i] == 16'h0000));
         if (ra[i] != 16'h0000) begin
            check(20'(n_run - k), 20'h1);
            check(20'(run_addr), 20'(ra[i]));
            check(20'(run_custom), 20'(pe[i] && ra[i] >= 16'h1000
               && ra[i] < 16'h3FFF));
         end else
            check(20'(n_run - k), 20'h0);
      end
      $display("test run and freeze done");
      wr(8'h68, '{8'hE0, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00, 8'h00, 8'h08,
         8'h02, 8'h34, 8'h00, 8'h01, 8'h23, 8'h45});
      wr(8'h68, '{8'hC0, 8'h00, 8'h00, 8'h02, 8'h01, 8'h00});
      rd('{16'h0008, 16'h0234, 16'h0001, 16'h2345});
      wr(8'h68, '{8'hF0, 8'h00, 8'h00, 8'h01, 8'h00, 8'h10, 8'h00, 8'h08,
         8'h02, 8'h34});
      wr(8'h68, '{8'hF4, 8'h00, 8'h00, 8'h01, 8'h00, 8'h10, 8'hAB,
         8'hCD});
      wr(8'h68, '{8'hD0, 8'h00, 8'h00, 8'h01, 8'h00, 8'h10});
      rd('{16'h0000, 16'hABCD});
      wr(8'h68, '{8'hD4, 8'h00, 8'h00, 8'h01, 8'h00, 8'h10});
      rd('{16'hABCD});
      $display("test memory done");
      wr(8'h68, '{8'hAC, 8'h80});
      rd('{16'h0008, 16'h5AC8});
      k = n_anc;
      wr(8'h68, '{8'h50, 8'h00});
      rd('{16'h1357, 16'h1357});
      check(20'(n_anc - k), 20'h1);
      $display("test register and anc read done");
      for (int f = 0; f < 16; f++) begin
         wr(8'h76, '{8'h00, 8'(f)});
         check(20'(dcdc_freq_sel), 20'(f));
      end
      $display("test converter done");
      wr(8'h68, '{8'h60, 8'h02, 8'h02, 8'h00});
      check(20'(dl_busy), 20'h1);
      clk_en = 1'b0;
      parallel_io_port(16'hFFFF);
      clk_en = 1'b1;
      check(20'(dl_busy), 20'h1);
      parallel_io_port(16'h0001);
      parallel_io_port(16'h2345);
      parallel_io_port(16'h0006);
      parallel_io_port(16'h789A);
      settle();
      check(20'(dl_busy), 20'h0);
      wr(8'h68, '{8'hC0, 8'h00, 8'h00, 8'h02, 8'h02, 8'h00});
      rd('{16'h0001, 16'h2345, 16'h0006, 16'h789A});
      $display("test download done");
      report_and_stop();
   end
endmodule : tb_dsp_core_access
